/* flash_power_pkg.sv */
// Shared constants and types for the flash power-up and busy sequencer.
// Assumes a single 10 MHz core clock; all times but the first-read delay are converted to cycles of it.
`default_nettype none

package flash_power_pkg;

	localparam int unsigned CLK_MHZ = 10;
	localparam int unsigned CNT_W = 26;

	// Worst-case times in microseconds.
	localparam int unsigned POWER_UP_WRITE_DELAY_US = 3000;
	localparam int unsigned SUPPLY_TO_FIRST_READ_DELAY_US = 70;
	localparam int unsigned PAGE_WRITE_BUSY_US = 2500;
	localparam int unsigned SECURITY_AREA_WRITE_BUSY_US = 950;
	localparam int unsigned PAGE_CLEAR_BUSY_US = 20000;
	localparam int unsigned BLOCK4_CLEAR_BUSY_US = 60000;
	localparam int unsigned BLOCK32_CLEAR_BUSY_US = 500000;
	localparam int unsigned BLOCK64_CLEAR_BUSY_US = 1000000;
	localparam int unsigned WHOLE_ARRAY_CLEAR_BUSY_US = 4000000;
	localparam int unsigned STATUS_WRITE_BUSY_US = 200;

	// Longest times round up, which an integer product of whole microseconds already does.
	localparam int unsigned POWER_UP_WRITE_DELAY_CYC = POWER_UP_WRITE_DELAY_US * CLK_MHZ;
	localparam int unsigned PAGE_WRITE_BUSY_CYC = PAGE_WRITE_BUSY_US * CLK_MHZ;
	localparam int unsigned SECURITY_AREA_WRITE_BUSY_CYC = SECURITY_AREA_WRITE_BUSY_US * CLK_MHZ;
	localparam int unsigned PAGE_CLEAR_BUSY_CYC = PAGE_CLEAR_BUSY_US * CLK_MHZ;
	localparam int unsigned BLOCK4_CLEAR_BUSY_CYC = BLOCK4_CLEAR_BUSY_US * CLK_MHZ;
	localparam int unsigned BLOCK32_CLEAR_BUSY_CYC = BLOCK32_CLEAR_BUSY_US * CLK_MHZ;
	localparam int unsigned BLOCK64_CLEAR_BUSY_CYC = BLOCK64_CLEAR_BUSY_US * CLK_MHZ;
	localparam int unsigned WHOLE_ARRAY_CLEAR_BUSY_CYC = WHOLE_ARRAY_CLEAR_BUSY_US * CLK_MHZ;
	localparam int unsigned STATUS_WRITE_BUSY_CYC = STATUS_WRITE_BUSY_US * CLK_MHZ;

	localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 26'h0000001;

	typedef enum logic [2:0] {
		OP_PAGE_WRITE = 3'h0,
		OP_SECURITY_WRITE = 3'h1,
		OP_PAGE_CLEAR = 3'h2,
		OP_BLOCK4_CLEAR = 3'h3,
		OP_BLOCK32_CLEAR = 3'h4,
		OP_BLOCK64_CLEAR = 3'h5,
		OP_WHOLE_CLEAR = 3'h6,
		OP_STATUS_WRITE = 3'h7
	} op_kind_t;

	typedef enum logic [1:0] {
		PWR_RESET = 2'h0,
		PWR_WAIT = 2'h1,
		PWR_STANDBY = 2'h2,
		PWR_ACTIVE = 2'h3
	} pwr_state_t;

	typedef struct packed {
		logic valid;
		op_kind_t kind;
	} op_req_t;

	typedef struct packed {
		logic drive;
		logic data;
	} so_req_t;

endpackage

`default_nettype wire

/* flash_power_seq.sv */
// Power-up, chip-select arming, mode select and internal busy timing of a serial flash.
// Assumes the POR circuit drives reset_n_i, SPI pins arrive asynchronously, and the
// command decoder on ref_clk_i issues operation starts and output-drive requests.
// The decoder is expected to poll busy_o; a request that arrives while busy is only
// reported through op_refused_o and otherwise has no effect.
// All busy and delay times are cycle counts of ref_clk_i; the parameters below set all but the status write busy time.
`timescale 1ns/1ps
`default_nettype none

module flash_power_seq #(
	parameter int unsigned PWR_DELAY_CYC = flash_power_pkg::POWER_UP_WRITE_DELAY_CYC,
	parameter int unsigned PAGE_WR_CYC = flash_power_pkg::PAGE_WRITE_BUSY_CYC,
	parameter int unsigned SEC_WR_CYC = flash_power_pkg::SECURITY_AREA_WRITE_BUSY_CYC,
	parameter int unsigned PAGE_CLR_CYC = flash_power_pkg::PAGE_CLEAR_BUSY_CYC,
	parameter int unsigned BLK4_CLR_CYC = flash_power_pkg::BLOCK4_CLEAR_BUSY_CYC,
	parameter int unsigned BLK32_CLR_CYC = flash_power_pkg::BLOCK32_CLEAR_BUSY_CYC,
	parameter int unsigned BLK64_CLR_CYC = flash_power_pkg::BLOCK64_CLEAR_BUSY_CYC,
	parameter int unsigned WHOLE_CLR_CYC = flash_power_pkg::WHOLE_ARRAY_CLEAR_BUSY_CYC
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire flash_power_pkg::op_req_t op_req_i,
	input wire flash_power_pkg::so_req_t so_req_i,
	output logic so_o,
	output logic so_oe_o,
	output logic cmd_enable_o,
	output logic mode3_o,
	output logic busy_o,
	output logic op_done_o,
	output logic op_refused_o,
	output flash_power_pkg::pwr_state_t pwr_state_o
);
	import flash_power_pkg::*;

	// Every flip-flop of the block lives in this one record, so that reset and the
	// next-state logic cannot miss a field.
	// The two pin synchronisers come first; only their second stage feeds logic.
	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic sck_meta;
		logic sck_sync;
		logic armed;
		logic cmd_active;
		logic mode3;
		pwr_state_t pwr;
		logic [CNT_W-1:0] pud_cnt;
		logic pending;
		op_kind_t pend_kind;
		logic busy;
		logic [CNT_W-1:0] busy_cnt;
		logic done;
		logic refused;
		logic so;
		logic so_oe;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// Worst-case busy time per kind, used both for a direct start and a deferred one.
	// The worst case is used on purpose: a host that polls never sees a shorter busy.
	function automatic logic [CNT_W-1:0] busy_cycles(input op_kind_t kind);
		logic [CNT_W-1:0] cyc;
		cyc = CNT_ONE;
		unique case (kind)
			OP_PAGE_WRITE: cyc = CNT_W'(PAGE_WR_CYC);
			OP_SECURITY_WRITE: cyc = CNT_W'(SEC_WR_CYC);
			OP_PAGE_CLEAR: cyc = CNT_W'(PAGE_CLR_CYC);
			OP_BLOCK4_CLEAR: cyc = CNT_W'(BLK4_CLR_CYC);
			OP_BLOCK32_CLEAR: cyc = CNT_W'(BLK32_CLR_CYC);
			OP_BLOCK64_CLEAR: cyc = CNT_W'(BLK64_CLR_CYC);
			OP_WHOLE_CLEAR: cyc = CNT_W'(WHOLE_CLR_CYC);
			OP_STATUS_WRITE: cyc = CNT_W'(STATUS_WRITE_BUSY_CYC);
		endcase
		return cyc;
	endfunction

	logic cs_fall;
	logic delay_over;
	logic is_array_op;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.refused = 1'b0;

		nxt_st.cs_meta = cs_n_i;
		nxt_st.cs_sync = st_ff.cs_meta;
		nxt_st.cs_prev = st_ff.cs_sync;
		nxt_st.sck_meta = sck_i;
		nxt_st.sck_sync = st_ff.sck_meta;

		cs_fall = st_ff.cs_prev && !st_ff.cs_sync;
		delay_over = (st_ff.pud_cnt == CNT_ZERO);
		is_array_op = (op_req_i.kind != OP_STATUS_WRITE);

		if (cs_fall) begin
			nxt_st.armed = 1'b1;
			nxt_st.mode3 = st_ff.sck_sync;
		end
		// Commands count only inside a frame that follows the first chip select fall.
		nxt_st.cmd_active = (st_ff.armed || cs_fall) && !st_ff.cs_sync;

		// The power state leaves reset on the first edge, counts the power-up delay and
		// then follows the synchronised chip select level.
		// Reads are never held back by this delay; only array operations wait for it.
		unique case (st_ff.pwr)
			PWR_RESET: begin
				nxt_st.pwr = PWR_WAIT;
			end
			PWR_WAIT: begin
				if (!delay_over) begin
					nxt_st.pud_cnt = st_ff.pud_cnt - CNT_ONE;
				end else begin
					nxt_st.pwr = st_ff.cs_sync ? PWR_STANDBY : PWR_ACTIVE;
				end
			end
			PWR_STANDBY: begin
				nxt_st.pwr = st_ff.cs_sync ? PWR_STANDBY : PWR_ACTIVE;
			end
			PWR_ACTIVE: begin
				nxt_st.pwr = st_ff.cs_sync ? PWR_STANDBY : PWR_ACTIVE;
			end
		endcase

		// A request that finds the block busy or holding a deferred one is dropped.
		if (op_req_i.valid) begin
			if (st_ff.busy || st_ff.pending || !st_ff.armed) begin
				nxt_st.refused = 1'b1;
			end else if (is_array_op && (st_ff.pwr == PWR_WAIT || st_ff.pwr == PWR_RESET)) begin
				nxt_st.pending = 1'b1;
				nxt_st.pend_kind = op_req_i.kind;
				nxt_st.busy = 1'b1;
			end else begin
				nxt_st.busy = 1'b1;
				nxt_st.busy_cnt = busy_cycles(op_req_i.kind);
			end
		end

		// A deferred operation already shows busy; its countdown starts once the delay
		// has run out, so its total busy time includes the rest of that delay.
		if (st_ff.pending && st_ff.pwr != PWR_WAIT && st_ff.pwr != PWR_RESET) begin
			nxt_st.pending = 1'b0;
			nxt_st.busy_cnt = busy_cycles(st_ff.pend_kind);
		end

		// The count holds the cycles still to run; the last one lowers busy and pulses
		// done in the same update, so the two can never disagree.
		if (st_ff.busy && !st_ff.pending) begin
			if (st_ff.busy_cnt <= CNT_ONE) begin
				nxt_st.busy = 1'b0;
				nxt_st.busy_cnt = CNT_ZERO;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.busy_cnt = st_ff.busy_cnt - CNT_ONE;
			end
		end

		// Output drive is granted only inside an armed frame, so it is off after reset.
		nxt_st.so_oe = nxt_st.cmd_active && so_req_i.drive;
		nxt_st.so = nxt_st.so_oe && so_req_i.data;
	end

	// The POR is the asynchronous reset, which clears every operation in flight.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff <= '0;
			st_ff.cs_meta <= 1'b1;
			st_ff.cs_sync <= 1'b1;
			st_ff.cs_prev <= 1'b1;
			st_ff.pwr <= PWR_RESET;
			st_ff.pud_cnt <= CNT_W'(PWR_DELAY_CYC);
			st_ff.pend_kind <= OP_PAGE_WRITE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs are plain views of the registered state, with no logic in between.
	assign so_o = st_ff.so;
	assign so_oe_o = st_ff.so_oe;
	assign cmd_enable_o = st_ff.cmd_active;
	assign mode3_o = st_ff.mode3;
	assign busy_o = st_ff.busy;
	assign op_done_o = st_ff.done;
	assign op_refused_o = st_ff.refused;
	assign pwr_state_o = st_ff.pwr;

endmodule

`default_nettype wire

/* flash_power_seq_monitor.sv */
// Port-level checker for the flash power-up and busy sequencer.
// Assumes it is bound to flash_power_seq and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module flash_power_seq_monitor (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire flash_power_pkg::op_req_t op_req_i,
	input wire logic so_o,
	input wire logic so_oe_o,
	input wire logic cmd_enable_o,
	input wire logic mode3_o,
	input wire logic busy_o,
	input wire logic op_done_o,
	input wire logic op_refused_o,
	input wire flash_power_pkg::pwr_state_t pwr_state_o
);
	import flash_power_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_drive_in_frame: assert property (so_oe_o |-> cmd_enable_o) else $error("so driven idle");
	a_so_low_off: assert property (so_o |-> so_oe_o) else $error("so high undriven");
	a_mode_at_fall: assert property ($changed(mode3_o) |-> $rose(cmd_enable_o)) else $error("mode");
	a_enable_drops: assert property (cs_n_i[*5] |-> !cmd_enable_o) else $error("enable");
	a_take_op: assert property (op_req_i.valid && !busy_o && cmd_enable_o |=> busy_o)
		else $error("op not taken");
	a_done_at_fall: assert property (op_done_o == $fell(busy_o)) else $error("done");
	a_refuse_cause: assert property (op_refused_o |-> $past(op_req_i.valid)) else $error("ref");
	a_wait_no_done: assert property (pwr_state_o == PWR_WAIT |-> !op_done_o) else $error("wait");
	a_standby_cs: assert property (cs_n_i[*5] ##0 pwr_state_o[1] |-> pwr_state_o == PWR_STANDBY)
		else $error("standby");
	a_active_cs: assert property ((!cs_n_i)[*5] ##0 pwr_state_o[1] |-> pwr_state_o == PWR_ACTIVE)
		else $error("active");
endmodule
bind flash_power_seq flash_power_seq_monitor flash_power_seq_monitor_i (.ref_clk_i, .reset_n_i,
	.cs_n_i, .op_req_i, .so_o, .so_oe_o, .cmd_enable_o, .mode3_o, .busy_o, .op_done_o,
	.op_refused_o, .pwr_state_o);
`default_nettype wire

/* spi_host_model.sv */
// Host model that frames the chip-select and serial clock pins.
// Assumes the bench calls frame() from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic cs_n_o,
	output logic sck_o
);
	// Frames carry no read, so the first-read wait never comes into play.
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
	end
	// The clock rests at the idle level of the mode, so the device can pick it at the fall.
	task automatic frame(input logic m3, input int n);
		sck_o = m3;
		#337 cs_n_o = 1'b0;
		repeat (2 * n) #400 sck_o = ~sck_o;
		#400 cs_n_o = 1'b1;
	endtask
endmodule
`default_nettype wire

/* flash_power_seq_bench.sv */
// Self-checking bench for the flash power-up and busy sequencer.
// Assumes the host model drives the chip-select and serial clock pins.
`timescale 1ns/1ps
`default_nettype none
module flash_power_seq_bench;
	import flash_power_pkg::*;
	// Short busy counts keep the run brief; expectations use the same values.
	localparam int unsigned PD = 100;
	localparam int unsigned NC [7] = '{30, 24, 40, 44, 48, 52, 60};
	logic ref_clk_i, reset_n_i, cs_n_i, sck_i, so_o, so_oe_o, cmd_enable_o, mode3_o, busy_o;
	logic op_done_o, op_refused_o, m3;
	op_req_t op_req_i;
	so_req_t so_req_i;
	pwr_state_t pwr_state_o;
	int n_errors = 0, checks_done = 0, cyc = 0, seed = 56862, c, r;
	spi_host_model spi_host_model_i (.cs_n_o(cs_n_i), .sck_o(sck_i));
	flash_power_seq #(.PWR_DELAY_CYC(PD), .PAGE_WR_CYC(NC[0]), .SEC_WR_CYC(NC[1]),
		.PAGE_CLR_CYC(NC[2]), .BLK4_CLR_CYC(NC[3]), .BLK32_CLR_CYC(NC[4]),
		.BLK64_CLR_CYC(NC[5]), .WHOLE_CLR_CYC(NC[6])) flash_power_seq_i (.ref_clk_i, .reset_n_i,
		.cs_n_i, .sck_i, .op_req_i, .so_req_i, .so_o, .so_oe_o, .cmd_enable_o, .mode3_o,
		.busy_o, .op_done_o, .op_refused_o, .pwr_state_o);
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	function automatic int unsigned dur(input op_kind_t k);
		return (k == OP_STATUS_WRITE) ? STATUS_WRITE_BUSY_CYC : NC[k];
	endfunction
	// A second request lands mid-busy; it must be dropped without stretching the busy time.
	task automatic op(input op_kind_t k);
		c = 0;
		@(posedge ref_clk_i) op_req_i <= '{1'b1, k};
		forever begin
			@(posedge ref_clk_i) op_req_i <= '{c == 2, k};
			@(negedge ref_clk_i);
			if (busy_o !== 1'b1 || c > 9000) break;
			c++;
			if (c == 4) chk(op_refused_o, 1'b1);
		end
		chk(op_done_o, 1'b1);
	endtask
	task automatic frame_chk(input int n);
		fork spi_host_model_i.frame(m3, n); join_none
		repeat (10) @(negedge ref_clk_i);
		chk({cmd_enable_o, mode3_o, so_oe_o, so_o}, {1'b1, m3, 1'b1, so_req_i.data});
	endtask
	initial begin
		reset_n_i = 1'b0;
		op_req_i = '{1'b0, OP_PAGE_WRITE};
		so_req_i = '{1'b1, 1'b1};
		repeat (11) @(posedge ref_clk_i);
		op_req_i <= '{1'b1, OP_STATUS_WRITE};
		@(posedge ref_clk_i) reset_n_i <= 1'b1;
		op_req_i <= '{1'b0, OP_STATUS_WRITE};
		@(negedge ref_clk_i) chk({so_oe_o, busy_o, op_refused_o, pwr_state_o}, 5'h00);
		@(posedge ref_clk_i) op_req_i <= '{1'b1, OP_STATUS_WRITE};
		@(posedge ref_clk_i) op_req_i <= '{1'b0, OP_STATUS_WRITE};
		@(negedge ref_clk_i) chk({op_refused_o, busy_o, so_oe_o, pwr_state_o}, {3'h4, PWR_WAIT});
		$display("reset test done");
		r = $random(seed);
		m3 = r[0];
		so_req_i <= '{1'b1, r[1]};
		frame_chk(20);
		op(OP_PAGE_WRITE);
		chk(c > NC[0] && c <= PD + NC[0] + 2, 1'b1);
		chk(pwr_state_o, PWR_ACTIVE);
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			op(op_kind_t'(i < 8 ? i[2:0] : r[2:0]));
			chk(c, dur(op_kind_t'(i < 8 ? i[2:0] : r[2:0])));
			$display("op test %0d done", i);
		end
		m3 = ~m3;
		frame_chk(4);
		repeat (60) @(negedge ref_clk_i);
		chk({cmd_enable_o, so_oe_o, pwr_state_o}, {2'h0, PWR_STANDBY});
		$display("mode test done");
		complete_run();
	end
endmodule
`default_nettype wire
